// [dv/crs_core_regs_bench.sv]
// self-checking bench for the core register file
`timescale 1ns/1ps
module crs_core_regs_bench;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 ptr_sel = 1'b1;
  logic [3:0]           prog_bank = 4'h0;
  crs_pkg::crs_op_t     op;
  logic [11:0]          target;
  logic [11:0]          vector;
  logic [7:0]           offset;
  crs_pkg::crs_alu_t    alu;
  crs_pkg::crs_ds_req_t ds_req;
  logic [7:0]           ds_rdata_q;
  logic                 ds_hit_q;
  logic [11:0]          pc_q;
  logic [15:0]          fetch_addr_q;
  logic [7:0]           acc_q;
  logic [7:0]           ind_addr_q;
  logic                 carry_q;
  logic                 zero_q;
  crs_pkg::crs_ctx_t    ctx_q;
  int                   err_count = 0;
  int                   check_count = 0;

  always #10 clk = ~clk;

  crs_seq_model m (.clk(clk), .op(op), .target(target), .vector(vector), .offset(offset), .alu(alu), .ds_req(ds_req));

  crs_core_regs #(.BANK_W(4)) dut (.clk(clk), .rst_b(rst_b), .op(op), .target(target), .vector(vector),
    .offset(offset), .prog_bank(prog_bank), .ptr_sel(ptr_sel), .alu(alu), .ds_req(ds_req), .ds_rdata_q(ds_rdata_q),
    .ds_hit_q(ds_hit_q), .pc_q(pc_q), .fetch_addr_q(fetch_addr_q), .acc_q(acc_q), .ind_addr_q(ind_addr_q),
    .carry_q(carry_q), .zero_q(zero_q), .ctx_q(ctx_q));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic t_reset();
    check("pc", pc_q, crs_pkg::RESET_VECTOR);
    check("fetch", fetch_addr_q, 16'h0ffe);
    check("ctx", ctx_q, crs_pkg::CTX_NMI);
  endtask : t_reset

  task automatic t_regs();
    logic [7:0] a [5];
    a = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
    for (int i = 0; i < 5; i++)
    begin
      m.ds(1'b1, a[i], 8'h5a ^ 8'(i));
      m.ds(1'b0, a[i], 8'h00);
      check("hit", ds_hit_q, 1'b1);
      check("rdata", ds_rdata_q, 8'h5a ^ 8'(i));
    end
    check("acc", acc_q, 8'h5e);
    check("ind", ind_addr_q, 8'h5b);
    ptr_sel = 1'b0;
    m.ds(1'b1, 8'h7f, 8'ha5);
    m.ds(1'b0, 8'h7f, 8'h00);
    check("miss", ds_hit_q, 1'b0);
    check("miss data", ds_rdata_q, 8'h00);
    check("ind", ind_addr_q, 8'h5a);
  endtask : t_regs

  task automatic t_pc();
    prog_bank = 4'ha;
    m.exec(crs_pkg::OP_JUMP, 12'h100, 8'h00);
    check("jump", pc_q, 12'h100);
    m.exec(crs_pkg::OP_NEXT, 12'h000, 8'h00);
    check("next", pc_q, 12'h101);
    check("bank", fetch_addr_q, 16'ha101);
    m.exec(crs_pkg::OP_RELATIVE, 12'h000, 8'hf0);
    check("back", pc_q, 12'h0f1);
    m.exec(crs_pkg::OP_RELATIVE, 12'h000, 8'h7f);
    check("fwd", pc_q, 12'h170);
    m.exec(crs_pkg::OP_JUMP, 12'hfff, 8'h00);
    m.exec(crs_pkg::OP_NEXT, 12'h000, 8'h00);
    check("wrap", pc_q, 12'h000);
  endtask : t_pc

  task automatic t_stack();
    m.exec(crs_pkg::OP_JUMP, 12'h010, 8'h00);
    for (int i = 0; i < 7; i++)
      m.exec(crs_pkg::OP_CALL, 12'h200 + 12'(i), 8'h00);
    check("call", pc_q, 12'h206);
    check("acc kept", acc_q, 8'h5e);
    // seventh call pushed the oldest entry out
    for (int i = 5; i >= 0; i--)
    begin
      m.exec(crs_pkg::OP_SUBROUTINE_EXIT, 12'h000, 8'h00);
      check("pop", pc_q, 12'h200 + 12'(i));
    end
    m.exec(crs_pkg::OP_SUBROUTINE_EXIT, 12'h000, 8'h00);
    check("empty pop", pc_q, 12'h201);
  endtask : t_stack

  task automatic t_ctx();
    logic [11:0] p;
    m.alu_op(1'b1, 8'h00);
    check("nmi flags", {carry_q, zero_q}, 2'b11);
    check("acc", acc_q, 8'h00);
    p = pc_q;
    m.exec(crs_pkg::OP_CALL, 12'h300, 8'h00);
    m.exec(crs_pkg::OP_INTERRUPT_EXIT, 12'h000, 8'h00);
    check("interrupt_exit_op pc", pc_q, p);
    check("ctx", ctx_q, crs_pkg::CTX_NORMAL);
    check("normal flags", {carry_q, zero_q}, 2'b00);
    m.alu_op(1'b1, 8'h01);
    p = pc_q;
    m.exec(crs_pkg::OP_IRQ_ENTER, 12'h404, 8'h00);
    check("vector", pc_q, 12'h404);
    check("ctx", ctx_q, crs_pkg::CTX_IRQ);
    check("irq flags", {carry_q, zero_q}, 2'b00);
    m.alu_op(1'b0, 8'h00);
    check("irq flags", {carry_q, zero_q}, 2'b01);
    m.exec(crs_pkg::OP_INTERRUPT_EXIT, 12'h000, 8'h00);
    check("ret pc", pc_q, p);
    check("ctx", ctx_q, crs_pkg::CTX_NORMAL);
    check("kept flags", {carry_q, zero_q}, 2'b10);
    m.exec(crs_pkg::OP_NMI_ENTER, 12'h408, 8'h00);
    check("nmi kept", {carry_q, zero_q}, 2'b11);
  endtask : t_ctx

  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_regs();
    t_pc();
    t_stack();
    t_ctx();
    end_of_test();
  end

  // whole run is under two hundred cycles
  initial
  begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule : crs_core_regs_bench

// [dv/crs_core_regs_sva.sv]
// assertions on the core register file ports
`timescale 1ns/1ps
module crs_core_regs_sva
(
  input wire logic            clk,        // clock
  input wire logic            rst_b,      // reset, active low
  input crs_pkg::crs_op_t     op,         // sequencer op
  input wire logic [11:0]     target,     // jump or call address
  input wire logic [11:0]     vector,     // interrupt vector
  input wire logic [7:0]      offset,     // relative offset
  input wire logic            ptr_sel,    // pointer select
  input crs_pkg::crs_alu_t    alu,        // alu strobes
  input crs_pkg::crs_ds_req_t ds_req,     // data-space request
  input wire logic            ds_hit_q,   // access hit
  input wire logic [11:0]     pc_q,       // program counter
  input wire logic [7:0]      ind_addr_q, // indirect address
  input wire logic            zero_q,     // active zero
  input crs_pkg::crs_ctx_t    ctx_q       // running context
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ***************************************************************
  // program counter and context
  // ***************************************************************
  a_pc_step: assert property (op == crs_pkg::OP_NEXT |=> pc_q == $past(pc_q) + 12'h001)
    else $error("pc did not step by one");
  a_pc_load: assert property (op inside {crs_pkg::OP_JUMP, crs_pkg::OP_CALL} |=> pc_q == $past(target))
    else $error("pc missed jump or call target");
  a_pc_rel: assert property (op == crs_pkg::OP_RELATIVE |=>
    pc_q == $past(pc_q) + {{4{$past(offset[7])}}, $past(offset)})
    else $error("relative branch sum wrong");
  a_irq_vector: assert property (op == crs_pkg::OP_IRQ_ENTER |=> pc_q == $past(vector))
    else $error("pc missed interrupt vector");
  a_nmi_ctx: assert property (op == crs_pkg::OP_NMI_ENTER |=> ctx_q == crs_pkg::CTX_NMI)
    else $error("nmi entry did not select nmi context");
  a_irq_exit_ctx: assert property (op == crs_pkg::OP_INTERRUPT_EXIT && ctx_q == crs_pkg::CTX_IRQ |=>
    ctx_q == crs_pkg::CTX_NORMAL)
    else $error("irq return did not restore normal context");

  // ***************************************************************
  // data space and flags
  // ***************************************************************
  a_map_hit: assert property ((ds_req.rd || ds_req.wr) |=>
    ds_hit_q == ($past(ds_req.addr) inside {[8'h80:8'h83], 8'hff}))
    else $error("hit flag disagrees with map");
  a_ptr_ind: assert property (ds_req.wr && ds_req.addr == crs_pkg::ADDR_POINTER_SECOND && ptr_sel ##1 ptr_sel
    |-> ind_addr_q == $past(ds_req.wdata))
    else $error("indirect address not from pointer");
  a_zero_calc: assert property (alu.upd_zero && op == crs_pkg::OP_NEXT |=>
    zero_q == ($past(alu.result) == 8'h00))
    else $error("zero flag wrong");

  c_call: cover property (op == crs_pkg::OP_CALL);
  c_sub_exit: cover property (op == crs_pkg::OP_SUBROUTINE_EXIT);
  c_irq_enter: cover property (op == crs_pkg::OP_IRQ_ENTER);
endmodule : crs_core_regs_sva

bind crs_core_regs crs_core_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .op(op), .target(target), .vector(vector),
  .offset(offset), .ptr_sel(ptr_sel), .alu(alu), .ds_req(ds_req), .ds_hit_q(ds_hit_q), .pc_q(pc_q),
  .ind_addr_q(ind_addr_q), .zero_q(zero_q), .ctx_q(ctx_q));

// [dv/crs_seq_model.sv]
// sequencer, alu and data-space master driving the register file
`timescale 1ns/1ps
module crs_seq_model
(
  input  wire logic            clk,    // machine-cycle clock
  output crs_pkg::crs_op_t     op,     // op per cycle
  output logic [11:0]          target, // jump or call address
  output logic [11:0]          vector, // interrupt vector
  output logic [7:0]           offset, // relative offset
  output crs_pkg::crs_alu_t    alu,    // alu strobes
  output crs_pkg::crs_ds_req_t ds_req  // data-space request
);
  initial
  begin
    op = crs_pkg::OP_HOLD;
    target = 12'h000;
    vector = 12'h000;
    offset = 8'h00;
    alu = '0;
    ds_req = '0;
  end

  // each call lets one idle edge pass before driving, so a release and
  // the next request never fall in one time step
  task automatic idle_next();
    @(posedge clk);
    #1;
    op = crs_pkg::OP_HOLD;
    alu = '0;
    ds_req.rd = 1'b0;
    ds_req.wr = 1'b0;
    // released lines other than the address never keep the last value
    ds_req.wdata = ~ds_req.wdata;
    target = ~target;
    vector = ~vector;
    offset = ~offset;
  endtask : idle_next

  task automatic exec(input crs_pkg::crs_op_t o, input logic [11:0] t, input logic [7:0] off);
    @(posedge clk);
    #1;
    op = o;
    target = t;
    vector = t;
    offset = off;
    idle_next();
  endtask : exec

  task automatic ds(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    ds_req.rd = ~wr;
    ds_req.wr = wr;
    ds_req.addr = a;
    ds_req.wdata = d;
    idle_next();
  endtask : ds

  task automatic alu_op(input logic c, input logic [7:0] r);
    @(posedge clk);
    #1;
    op = crs_pkg::OP_NEXT;
    alu = '{wr_acc: 1'b1, upd_carry: 1'b1, upd_zero: 1'b1, carry: c, result: r};
    idle_next();
  endtask : alu_op
endmodule : crs_seq_model

// [verilog/crs_core_regs.sv]
// programmer-visible core state: data registers, pc, flags, return stack
// ***************************************************************
// Notes on behaviour
// - accumulator, eight bits, also data address ffh
// - pointers mapped at 80h and 81h
// - selected pointer supplies the indirect address
// - short-direct registers mapped at 82h, 83h
// - twelve-bit pc reaches 4096 program bytes
// - bank register extends reach beyond 4096 bytes
// - pc steps by one after each fetch
// - relative branch adds signed offset to pc
// - pc loads jump, call, vector, reset, pop
// - three carry/zero pairs, one per context
// - entry selects context pair; return restores previous
// - no clear on switch; own-context access only
// - carry from arithmetic, bit test, rotate
// - zero set when result equals zero
// - reset starts in non-maskable context
// - six-level twelve-bit return stack, no pointer
// - call or entry pushes pc, drops sixth
// - return pops first level into pc
// - only pc saved on the stack
// - overflow saturates; empty return falls through
// - reset clears stack, pc gets reset vector
// ***************************************************************
`timescale 1ns/1ps
module crs_core_regs
#(
  parameter int BANK_W = crs_pkg::BANK_W // program bank width
)
(
  input  wire logic              clk,         // machine-cycle clock
  input  wire logic              rst_b,       // async reset, active low
  input  crs_pkg::crs_op_t       op,          // sequencer pc/context op
  input  wire logic [11:0]       target,      // jump or call address
  input  wire logic [11:0]       vector,      // interrupt vector
  input  wire logic [7:0]        offset,      // signed relative offset
  input  wire logic [BANK_W-1:0] prog_bank,   // program bank register
  input  wire logic              ptr_sel,     // 0 first, 1 second pointer
  input  crs_pkg::crs_alu_t      alu,         // alu result and flags
  input  crs_pkg::crs_ds_req_t   ds_req,      // data-space access
  output logic [7:0]             ds_rdata_q,  // read data
  output logic                   ds_hit_q,    // access hit a core reg
  output logic [11:0]            pc_q,        // program counter
  output logic [BANK_W+11:0]     fetch_addr_q, // banked fetch address
  output logic [7:0]             acc_q,       // accumulator
  output logic [7:0]             ind_addr_q,  // indirect address
  output logic                   carry_q,     // active carry
  output logic                   zero_q,      // active zero
  output crs_pkg::crs_ctx_t      ctx_q        // running context
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [7:0]        ptr0_q;
  logic [7:0]        ptr1_q;
  logic [7:0]        sd0_q;
  logic [7:0]        sd1_q;
  logic [7:0]        acc_d;
  logic [7:0]        ptr0_d;
  logic [7:0]        ptr1_d;
  logic [11:0]       pc_d;
  logic [11:0]       pc_inc;
  logic [11:0]       pc_rel;
  crs_pkg::crs_ctx_t ctx_d;
  crs_pkg::crs_ctx_t nmi_prev_q;
  crs_pkg::crs_ctx_t nmi_prev_d;
  logic              push;
  logic              pop;
  logic [11:0]       stk_top;
  logic              stk_empty;
  logic              wr_hit;
  logic              flg_carry;
  logic              flg_zero;

  // one write strobe; each register decodes its own address
  assign wr_hit = ds_req.wr;

  // ***************************************************************
  // data-space registers
  // ***************************************************************
  // alu write to the accumulator wins over a bus write in one cycle
  always_comb
  begin
    acc_d = acc_q;
    if (alu.wr_acc)
      acc_d = alu.result;
    else if (wr_hit && ds_req.addr == crs_pkg::ADDR_ACCUMULATOR)
      acc_d = ds_req.wdata;
  end

  always_comb
  begin
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    if (wr_hit && ds_req.addr == crs_pkg::ADDR_POINTER_FIRST)
      ptr0_d = ds_req.wdata;
    if (wr_hit && ds_req.addr == crs_pkg::ADDR_POINTER_SECOND)
      ptr1_d = ds_req.wdata;
  end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      acc_q  <= crs_pkg::DATA_RESET;
      ptr0_q <= crs_pkg::DATA_RESET;
      ptr1_q <= crs_pkg::DATA_RESET;
    end
    else
    begin
      acc_q  <= acc_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      sd0_q <= crs_pkg::DATA_RESET;
      sd1_q <= crs_pkg::DATA_RESET;
    end
    else if (wr_hit)
    begin
      if (ds_req.addr == crs_pkg::ADDR_SHORT_DIRECT_FIRST)
        sd0_q <= ds_req.wdata;
      if (ds_req.addr == crs_pkg::ADDR_SHORT_DIRECT_SECOND)
        sd1_q <= ds_req.wdata;
    end

  // tracks the pointer value of the next cycle, so a write is seen at once
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      ind_addr_q <= crs_pkg::DATA_RESET;
    else
      ind_addr_q <= ptr_sel ? ptr1_d : ptr0_d;

  // ***************************************************************
  // data-space read port
  // ***************************************************************
  // read answers one cycle later with the post-write value
  // unmapped addresses answer zero with the hit flag low
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      ds_rdata_q <= crs_pkg::DATA_RESET;
      ds_hit_q   <= 1'b0;
    end
    else
    begin
      ds_hit_q   <= 1'b0;
      ds_rdata_q <= crs_pkg::DATA_RESET;
      if (ds_req.rd || ds_req.wr)
      begin
        ds_hit_q <= 1'b1;
        case (ds_req.addr)
          crs_pkg::ADDR_POINTER_FIRST:       ds_rdata_q <= ptr0_d;
          crs_pkg::ADDR_POINTER_SECOND:      ds_rdata_q <= ptr1_d;
          crs_pkg::ADDR_SHORT_DIRECT_FIRST:  ds_rdata_q <= ds_req.wr ? ds_req.wdata : sd0_q;
          crs_pkg::ADDR_SHORT_DIRECT_SECOND: ds_rdata_q <= ds_req.wr ? ds_req.wdata : sd1_q;
          crs_pkg::ADDR_ACCUMULATOR:         ds_rdata_q <= acc_d;
          default:                           ds_hit_q   <= 1'b0;
        endcase
      end
    end

  // ***************************************************************
  // program counter
  // ***************************************************************
  assign pc_inc = pc_q + crs_pkg::PC_ONE;
  assign pc_rel = pc_q + {{4{offset[7]}}, offset};

  always_comb
  begin
    pc_d = pc_q;
    push = 1'b0;
    pop  = 1'b0;
    case (op)
      crs_pkg::OP_HOLD:
        pc_d = pc_q;
      crs_pkg::OP_NEXT:
        pc_d = pc_inc;
      crs_pkg::OP_JUMP:
        pc_d = target;
      crs_pkg::OP_CALL:
      begin
        pc_d = target;
        push = 1'b1;
      end
      crs_pkg::OP_RELATIVE:
        pc_d = pc_rel;
      crs_pkg::OP_IRQ_ENTER, crs_pkg::OP_NMI_ENTER:
      begin
        pc_d = vector;
        push = 1'b1;
      end
      crs_pkg::OP_SUBROUTINE_EXIT, crs_pkg::OP_INTERRUPT_EXIT:
      begin
        pop  = 1'b1;
        pc_d = stk_empty ? pc_inc : stk_top;
      end
      default:
        pc_d = pc_q;
    endcase
  end

  // ***************************************************************
  // return stack
  // ***************************************************************
  // pc only is pushed: data registers are left to the software
  crs_stack #(
    .DEPTH (crs_pkg::STACK_DEPTH),
    .WIDTH (crs_pkg::PC_W)
  ) u_stack (
    .clk   (clk),
    .rst_b (rst_b),
    .push  (push),
    .pop   (pop),
    .din   (pc_q),
    .top   (stk_top),
    .empty (stk_empty)
  );

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      pc_q <= crs_pkg::RESET_VECTOR;
    else
      pc_q <= pc_d;

  // ***************************************************************
  // fetch address
  // ***************************************************************
  // bank bits extend the fetch beyond the 4096-byte pc reach
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      fetch_addr_q <= {{BANK_W{1'b0}}, crs_pkg::RESET_VECTOR};
    else
      fetch_addr_q <= {prog_bank, pc_d};

  // ***************************************************************
  // execution context
  // ***************************************************************
  // nmi may preempt irq, so the context under an nmi is remembered
  // limitation: an irq entered under nmi keeps the nmi flags, and
  // its return ends the nmi context early
  always_comb
  begin
    ctx_d      = ctx_q;
    nmi_prev_d = nmi_prev_q;
    case (op)
      crs_pkg::OP_IRQ_ENTER:
        if (ctx_q == crs_pkg::CTX_NORMAL)
          ctx_d = crs_pkg::CTX_IRQ;
      crs_pkg::OP_NMI_ENTER:
        if (ctx_q != crs_pkg::CTX_NMI)
        begin
          nmi_prev_d = ctx_q;
          ctx_d      = crs_pkg::CTX_NMI;
        end
      crs_pkg::OP_INTERRUPT_EXIT:
        if (ctx_q == crs_pkg::CTX_NMI)
          ctx_d = nmi_prev_q;
        else
          ctx_d = crs_pkg::CTX_NORMAL;
      default:
        ctx_d = ctx_q;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      ctx_q      <= crs_pkg::CTX_NMI;
      nmi_prev_q <= crs_pkg::CTX_NORMAL;
    end
    else
    begin
      ctx_q      <= ctx_d;
      nmi_prev_q <= nmi_prev_d;
    end

  // ***************************************************************
  // flags
  // ***************************************************************
  crs_flags u_flags (
    .clk       (clk),
    .rst_b     (rst_b),
    .ctx       (ctx_q),
    .ctx_next  (ctx_d),
    .upd_carry (alu.upd_carry),
    .upd_zero  (alu.upd_zero),
    .carry_in  (alu.carry),
    .zero_in   (alu.result == 8'h00),
    .carry_q   (flg_carry),
    .zero_q    (flg_zero)
  );

  // ***************************************************************
  // flag outputs
  // ***************************************************************
  // the flag block already registers the pair of the coming cycle
  assign carry_q = flg_carry;
  assign zero_q  = flg_zero;

endmodule : crs_core_regs

// [verilog/crs_flags.sv]
// three carry/zero pairs, one per execution context
`timescale 1ns/1ps
module crs_flags
(
  input  wire logic             clk,       // machine-cycle clock
  input  wire logic             rst_b,     // async reset, active low
  input  crs_pkg::crs_ctx_t     ctx,       // context in force this cycle
  input  crs_pkg::crs_ctx_t     ctx_next,  // context for the next cycle
  input  wire logic             upd_carry, // write the active carry
  input  wire logic             upd_zero,  // write the active zero
  input  wire logic             carry_in,  // new carry value
  input  wire logic             zero_in,   // new zero value
  output logic                  carry_q,   // carry of next active pair
  output logic                  zero_q     // zero of next active pair
);

  logic [2:0] c_q;
  logic [2:0] z_q;
  logic [2:0] c_d;
  logic [2:0] z_d;

  // ***************************************************************
  // per-context pairs
  // ***************************************************************
  // only the pair of the running context moves; others keep state
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pair
      always_comb
      begin
        c_d[g] = c_q[g];
        z_d[g] = z_q[g];
        if (ctx == crs_pkg::crs_ctx_t'(g))
        begin
          if (upd_carry)
            c_d[g] = carry_in;
          if (upd_zero)
            z_d[g] = zero_in;
        end
      end

      // no clear on switch: pairs hold across context changes
      always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
          c_q[g] <= 1'b0;
          z_q[g] <= 1'b0;
        end
        else
        begin
          c_q[g] <= c_d[g];
          z_q[g] <= z_d[g];
        end
    end
  endgenerate

  // registered copy of the pair that will be active
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
    end
    else
    begin
      carry_q <= c_d[ctx_next];
      zero_q  <= z_d[ctx_next];
    end

endmodule : crs_flags

// [verilog/crs_pkg.sv]
// shared constants, types and carriers of the core register file
package crs_pkg;

  // ***************************************************************
  // data-space map
  // ***************************************************************
  localparam logic [7:0] ADDR_POINTER_FIRST      = 8'h80;
  localparam logic [7:0] ADDR_POINTER_SECOND     = 8'h81;
  localparam logic [7:0] ADDR_SHORT_DIRECT_FIRST = 8'h82;
  localparam logic [7:0] ADDR_SHORT_DIRECT_SECOND = 8'h83;
  localparam logic [7:0] ADDR_ACCUMULATOR        = 8'hff;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int          DATA_W      = 8;
  localparam int          PC_W        = 12;
  localparam int          STACK_DEPTH = 6;
  localparam int          BANK_W      = 4;
  localparam logic [11:0] RESET_VECTOR = 12'hffe;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [11:0] PC_ONE       = 12'h001;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {CTX_NORMAL, CTX_IRQ, CTX_NMI} crs_ctx_t;

  typedef enum logic [3:0] {
    OP_HOLD,
    OP_NEXT,
    OP_JUMP,
    OP_CALL,
    OP_RELATIVE,
    OP_IRQ_ENTER,
    OP_NMI_ENTER,
    OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_EXIT
  } crs_op_t;

  typedef struct packed {
    logic       wr_acc;
    logic       upd_carry;
    logic       upd_zero;
    logic       carry;
    logic [7:0] result;
  } crs_alu_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crs_ds_req_t;

endpackage : crs_pkg

// [verilog/crs_stack.sv]
// six-level hardware return stack, outside data space
`timescale 1ns/1ps
module crs_stack
#(
  parameter int DEPTH = crs_pkg::STACK_DEPTH, // number of levels
  parameter int WIDTH = crs_pkg::PC_W         // bits per level
)
(
  input  wire logic             clk,   // machine-cycle clock
  input  wire logic             rst_b, // async reset, active low
  input  wire logic             push,  // call or interrupt entry
  input  wire logic             pop,   // either return
  input  wire logic [WIDTH-1:0] din,   // value to push
  output logic      [WIDTH-1:0] top,   // first level
  output logic                  empty  // nothing stacked
);

  logic [WIDTH-1:0]         lvl_q [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] cnt_q;

  // ***************************************************************
  // levels
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_lvl
      always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
          lvl_q[g] <= '0;
        else if (push)
        begin
          if (g == 0)
            lvl_q[g] <= din;
          else
            lvl_q[g] <= lvl_q[(g > 0) ? g - 1 : 0];
        end
        else if (pop && cnt_q != '0)
        begin
          if (g == DEPTH - 1)
            lvl_q[g] <= '0;
          else
            lvl_q[g] <= lvl_q[(g < DEPTH - 1) ? g + 1 : g];
        end
    end
  endgenerate

  // ***************************************************************
  // occupancy
  // ***************************************************************
  // saturates when full: the deepest entry is simply lost
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cnt_q <= '0;
    else if (push && cnt_q != DEPTH[$clog2(DEPTH+1)-1:0])
      cnt_q <= cnt_q + 1'b1;
    else if (pop && !push && cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;

  assign top   = lvl_q[0];
  assign empty = (cnt_q == '0);

endmodule : crs_stack
